// File: common/e2bl_params.svh
// Functional notes
// R1 - Device is slave only; master controls transfers
// R2 - Clock is input only; data line bidirectional
// R3 - Sample on clock rise, change on fall
// R4 - Bytes travel MSb first, one bit per clock
// R5 - Receiver answers ACK/NACK in ninth clock
// R6 - Master gives nine clocks, no breaks
// R7 - Data changes only while clock low
// R8 - Data edge with clock high is Start/Stop
// R9 - No limit on bytes between Start and Stop
// R10 - Bus idle only when both lines high
// R11 - Both inputs filtered against spikes, with hysteresis
// R12 - Ignore bus in reset, then enter standby
// R13 - Master waits power-up delay before commanding
// R14 - Start falls, Stop rises, clock high
// R15 - Transmitter releases at eighth fall; ACK low
// R16 - Master NACK on read makes device release
// R17 - Data line driven low or released only
// R18 - Driver released unless sending ACK or data
// R19 - Start/Stop mid-byte aborts and clears bit count
`ifndef E2BL_PARAMS_SVH
`define E2BL_PARAMS_SVH

`define E2BL_CLK_MHZ        100
`define E2BL_SPIKE_NS       100
// Inputs must hold a level this long before the filter accepts it
`define E2BL_FILT_CYC       ((`E2BL_SPIKE_NS * `E2BL_CLK_MHZ + 999) / 1000)
`define E2BL_BYTE_BITS      8
`define E2BL_ACK_SLOT       4'h8
`define E2BL_PUP_US         100
`define E2BL_CNT_RST        4'h0
// One below zero: the clock fall that closes a Start carries no bit
`define E2BL_CNT_START      4'hF

`endif

// File: common/e2bl_pkg.sv
`default_nettype none
package e2bl_pkg;
	typedef enum {ST_STANDBY, ST_ACTIVE} e2bl_state_t;
	typedef logic [3:0] e2bl_bitcnt_t;
endpackage
`default_nettype wire

// File: hdl/e2bl_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "e2bl_params.svh"

module e2bl_slave
	import e2bl_pkg::*;
#(
	parameter int FILT_CYC = `E2BL_FILT_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       en_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	input  wire logic       tx_mode_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       ack_en_i,
	output logic [7:0]      rx_byte_o,
	output logic            rx_valid_o,
	output logic            ack_seen_o,
	output logic            nack_o,
	output logic            start_o,
	output logic            stop_o,
	output logic            bus_idle_o,
	output logic            standby_o
);

	localparam int FW = $clog2(FILT_CYC + 1);

	logic [1:0]   pin_w;
	logic [1:0]   filt_w;
	logic         scl_f;
	logic         sda_f;
	logic         scl_p_r;
	logic         sda_p_r;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_ev;
	logic         stop_ev;
	e2bl_state_t  state_r;
	e2bl_bitcnt_t bit_cnt_r;
	e2bl_bitcnt_t bit_cnt_nxt;
	logic [7:0]   rx_sh_r;
	logic [7:0]   tx_r;
	logic         tx_mode_r;
	logic         drive_r;

	assign pin_w = {sda_i, scl_i};

	// Two-stage synchroniser, then a stability counter per line. A new level is
	// taken only after it holds FILT_CYC cycles, which both kills spikes and
	// gives hysteresis around the accepted level.
	generate
		for (genvar i = 0; i < 2; i++) begin : g_filt
			logic          s1_r;
			logic          s2_r;
			logic          lvl_r;
			logic [FW-1:0] cnt_r;

			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					s1_r <= 1'b1;
					s2_r <= 1'b1;
				end else if (en_i) begin
					s1_r <= pin_w[i];
					s2_r <= s1_r;
				end
			end

			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					lvl_r <= 1'b1;
					cnt_r <= '0;
				end else if (en_i) begin
					if (s2_r == lvl_r) begin
						cnt_r <= '0;
					end else if (cnt_r == FW'(FILT_CYC - 1)) begin
						lvl_r <= s2_r; // [R11]
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
			end

			assign filt_w[i] = lvl_r;
		end
	endgenerate

	assign scl_f = filt_w[0];
	assign sda_f = filt_w[1];

	// Previous filtered levels for edge detection
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end else if (en_i) begin
			scl_p_r <= scl_f;
			sda_p_r <= sda_f;
		end
	end

	// Clock is only ever observed, never driven [R2]
	assign scl_rise = en_i & scl_f & ~scl_p_r;
	assign scl_fall = en_i & ~scl_f & scl_p_r;
	// Data edge while clock stays high is a condition, not a bit [R8] [R14]
	assign start_ev = en_i & scl_f & scl_p_r & sda_p_r & ~sda_f;
	assign stop_ev  = en_i & scl_f & scl_p_r & ~sda_p_r & sda_f;

	// Bit counter advances on each fall; wraps after the ack slot, no byte limit
	assign bit_cnt_nxt = (bit_cnt_r == `E2BL_ACK_SLOT) ? `E2BL_CNT_RST : bit_cnt_r + 4'h1; // [R9]

	// Session state: Start wakes the slave, Stop or a master NACK on a read returns to standby
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= ST_STANDBY; // [R12]
		end else if (start_ev) begin
			state_r <= ST_ACTIVE; // [R1]
		end else if (stop_ev) begin
			state_r <= ST_STANDBY;
		end else if (scl_rise && state_r == ST_ACTIVE && tx_mode_r &&
			bit_cnt_r == `E2BL_ACK_SLOT && sda_f) begin
			state_r <= ST_STANDBY; // [R16]
		end
	end

	// Bit framing; a condition mid-byte restarts framing from bit zero
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bit_cnt_r <= `E2BL_CNT_RST;
		end else if (start_ev) begin
			// The fall that ends the Start wraps this to zero, so bit one counts as zero
			bit_cnt_r <= `E2BL_CNT_START; // [R19]
		end else if (stop_ev) begin
			bit_cnt_r <= `E2BL_CNT_RST; // [R19]
		end else if (scl_fall && state_r == ST_ACTIVE) begin
			bit_cnt_r <= bit_cnt_nxt; // [R4] [R6]
		end
	end

	// Receive shift on the rising edge, MSb enters first
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_sh_r <= 8'h00;
		end else if (scl_rise && state_r == ST_ACTIVE && bit_cnt_r < `E2BL_ACK_SLOT) begin
			rx_sh_r <= {rx_sh_r[6:0], sda_f}; // [R3] [R4]
		end
	end

	// Byte delivery and ninth-clock answer from the master
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_byte_o  <= 8'h00;
			rx_valid_o <= 1'b0;
			ack_seen_o <= 1'b0;
			nack_o     <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			ack_seen_o <= 1'b0;
			if (scl_rise && state_r == ST_ACTIVE) begin
				if (bit_cnt_r == 4'h7 && !tx_mode_r) begin
					rx_byte_o  <= {rx_sh_r[6:0], sda_f};
					rx_valid_o <= 1'b1;
				end
				if (bit_cnt_r == `E2BL_ACK_SLOT && tx_mode_r) begin
					ack_seen_o <= 1'b1; // [R5]
					nack_o     <= sda_f;
				end
			end
		end
	end

	// Direction and data of the next byte are taken at each byte boundary
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_mode_r <= 1'b0;
			tx_r      <= 8'h00;
		end else if (start_ev || stop_ev) begin
			tx_mode_r <= 1'b0; // Address byte after Start is always inbound
		end else if (scl_fall && state_r == ST_ACTIVE && bit_cnt_r == `E2BL_ACK_SLOT) begin
			tx_mode_r <= tx_mode_i;
			tx_r      <= tx_data_i;
		end
	end

	// Open-drain driver, set only on a falling clock edge; Start, Stop or standby release it at once
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			drive_r <= 1'b0;
		end else if (start_ev || stop_ev || state_r != ST_ACTIVE) begin
			drive_r <= 1'b0; // [R18]
		end else if (scl_fall) begin // [R3] [R7]
			if (bit_cnt_r == `E2BL_ACK_SLOT) begin
				drive_r <= tx_mode_i & ~tx_data_i[7];
			end else if (bit_cnt_nxt == `E2BL_ACK_SLOT) begin
				drive_r <= ~tx_mode_r & ack_en_i; // [R15]
			end else begin
				drive_r <= tx_mode_r & ~tx_r[3'(7 - bit_cnt_nxt)];
			end
		end
	end

	assign sda_o      = 1'b0; // [R17]
	assign sda_oe_n_o = ~drive_r;

	// Status pulses and levels, all from flip-flops
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			start_o    <= 1'b0;
			stop_o     <= 1'b0;
			bus_idle_o <= 1'b1;
		end else begin
			start_o <= start_ev;
			stop_o  <= stop_ev;
			if (en_i) begin
				bus_idle_o <= scl_f & sda_f; // [R10]
			end
		end
	end

	assign standby_o = (state_r == ST_STANDBY);

	// Checks
	sequence s_fall;
		scl_fall && state_r == ST_ACTIVE && !start_ev && !stop_ev;
	endsequence

	drive_on_fall_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R3]
		$rose(drive_r) |-> $past(scl_fall))
		else $error("data driver rose away from a clock fall");
	rise_sample_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R4]
		scl_rise && state_r == ST_ACTIVE && bit_cnt_r < 4'h8 |=> rx_sh_r[0] == $past(sda_f))
		else $error("bit not sampled on rising edge");
	byte_done_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R5]
		scl_rise && state_r == ST_ACTIVE && bit_cnt_r == 4'h7 && !tx_mode_r
		|=> rx_valid_o && rx_byte_o[0] == $past(sda_f))
		else $error("byte not delivered after eighth bit");
	start_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R19]
		start_ev |=> bit_cnt_r == `E2BL_CNT_START && state_r == ST_ACTIVE && !drive_r
			##1 start_o == 1'b0)
		else $error("start did not restart framing");
	stop_standby_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R12]
		stop_ev && !start_ev |=> standby_o && !drive_r && stop_o)
		else $error("stop did not return to standby");
	bus_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R10]
		en_i |=> bus_idle_o == ($past(scl_f) && $past(sda_f)))
		else $error("idle flag wrong");
	drive_release_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R18]
		drive_r |-> state_r == ST_ACTIVE && (tx_mode_r || bit_cnt_r == 4'h8 || bit_cnt_r == 4'h0))
		else $error("driver active outside ack or data");
	nack_release_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R16]
		scl_rise && state_r == ST_ACTIVE && tx_mode_r && bit_cnt_r == 4'h8 && sda_f && !start_ev
		|=> standby_o ##1 !drive_r)
		else $error("nack did not release the line");
	ack_drive_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R15]
		s_fall ##0 (bit_cnt_r == 4'h7 && !tx_mode_r && ack_en_i) |=> drive_r && bit_cnt_r == 4'h8)
		else $error("ack not driven after eighth fall");
	filter_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R11]
		en_i && $changed(scl_f) |-> $past(g_filt[0].cnt_r) == FW'(FILT_CYC - 1))
		else $error("clock level accepted before filter time");

endmodule
`default_nettype wire

// File: verification/e2bl_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module e2bl_master_model #(
	parameter int QTR_NS = 200
) (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_drv_n_o
);
	// Clock driven high and data line released at rest; the pull-up gives the data high level
	initial begin
		scl_o = 1'b1;
		sda_drv_n_o = 1'b1;
	end
	// Data falls while the clock is high
	task automatic start();
		sda_drv_n_o = 1'b1;
		#QTR_NS scl_o = 1'b1;
		#QTR_NS sda_drv_n_o = 1'b0;
		#QTR_NS scl_o = 1'b0;
		#QTR_NS;
	endtask
	// Data rises while the clock is high
	task automatic stop();
		sda_drv_n_o = 1'b0;
		#QTR_NS scl_o = 1'b1;
		#QTR_NS sda_drv_n_o = 1'b1;
		#QTR_NS;
	endtask
	// A low pulse far shorter than the filter span
	task automatic glitch();
		#QTR_NS sda_drv_n_o = 1'b0;
		#10 sda_drv_n_o = 1'b1;
		#QTR_NS;
	endtask
	// Up to nine clocks, MSb first, no pause; data moves only while low
	// A 1 in bit 0 releases the line in the ninth clock, which is a NACK
	task automatic xfer(input int n, input logic [8:0] out, output logic [8:0] in);
		in = 9'h1ff;
		for (int i = 8; i > 8 - n; i--) begin
			sda_drv_n_o = out[i];
			#QTR_NS scl_o = 1'b1;
			#QTR_NS in[i] = sda_i;
			#QTR_NS scl_o = 1'b0;
			#QTR_NS;
		end
	endtask
endmodule
`default_nettype wire

// File: verification/e2bl_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module e2bl_slave_tb;
	import e2bl_pkg::*;
	localparam int PUP_CYC = 10000; // power_up_command_delay of 100 us at 100 MHz
	logic clk_i, nrst_i, en_i, tx_mode_i, ack_en_i, scl_w, drv_n_w, sda_w;
	logic sda_o, sda_oe_n_o, rx_valid_o, ack_seen_o, nack_o, start_o, stop_o;
	logic bus_idle_o, standby_o;
	logic [7:0] tx_data_i, rx_byte_o;
	logic [8:0] in;
	int err_count, cmp_count, starts, stops, acks, valids;
	// Open-drain wire: low if either party pulls, else pull-up
	assign sda_w = drv_n_w & ((sda_oe_n_o === 1'b0) ? sda_o : 1'b1);
	e2bl_slave #(.FILT_CYC(2)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i),
		.scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
		.tx_mode_i(tx_mode_i), .tx_data_i(tx_data_i), .ack_en_i(ack_en_i),
		.rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o), .ack_seen_o(ack_seen_o),
		.nack_o(nack_o), .start_o(start_o), .stop_o(stop_o), .bus_idle_o(bus_idle_o),
		.standby_o(standby_o));
	e2bl_master_model mst (.sda_i(sda_w), .scl_o(scl_w), .sda_drv_n_o(drv_n_w));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Pulses are counted, since they stand for one cycle only
	always @(posedge clk_i) begin
		if (start_o === 1'b1) starts++;
		if (stop_o === 1'b1) stops++;
		if (ack_seen_o === 1'b1) acks++;
		if (rx_valid_o === 1'b1) valids++;
	end
	task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Offset of 3 ns keeps bus edges away from the sampling edge
	task automatic set_user(input logic m, input logic [7:0] d, input logic a);
		@(posedge clk_i);
		tx_mode_i <= m;
		tx_data_i <= d;
		ack_en_i <= a;
		#3;
	endtask
	task automatic t_reset();
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("oe_n", sda_oe_n_o, 1);
		chk("standby", standby_o, 1);
		chk("idle", bus_idle_o, 1);
		chk("rx", rx_byte_o, 0);
		repeat (PUP_CYC) @(posedge clk_i);
	endtask
	task automatic t_glitch();
		int s0 = starts;
		set_user(0, 8'h00, 1);
		mst.glitch();
		chk("glitch start", starts, s0);
		chk("glitch stby", standby_o, 1);
	endtask
	// Two inbound bytes: the first acknowledged, the second not
	task automatic t_write();
		int s0 = starts;
		int v0 = valids;
		mst.start();
		chk("start", starts, s0 + 1);
		chk("active", standby_o, 0);
		mst.xfer(9, {8'ha5, 1'b1}, in);
		chk("ack", in[0], 0);
		chk("rx a5", rx_byte_o, 8'ha5);
		set_user(0, 8'h00, 0);
		mst.xfer(9, {8'h3c, 1'b1}, in);
		chk("no ack", in[0], 1);
		chk("rx 3c", rx_byte_o, 8'h3c);
		chk("valid", valids, v0 + 2);
		chk("sda0", sda_o, 0);
	endtask
	// Repeated start, address, then two read bytes: ACK then NACK
	task automatic t_read();
		int a0;
		set_user(1, 8'h96, 1);
		mst.start();
		mst.xfer(9, {8'ha1, 1'b1}, in);
		chk("addr ack", in[0], 0);
		a0 = acks;
		mst.xfer(9, {8'hff, 1'b0}, in);
		chk("tx byte", in[8:1], 8'h96);
		chk("ack seen", acks, a0 + 1);
		chk("nack lo", nack_o, 0);
		mst.xfer(9, {8'hff, 1'b1}, in);
		chk("tx again", in[8:1], 8'h96);
		chk("nack", nack_o, 1);
		chk("nack stby", standby_o, 1);
		chk("released", sda_oe_n_o, 1);
		set_user(0, 8'h00, 1);
		mst.stop();
	endtask
	// Stop after four bits aborts; the next byte frames cleanly
	task automatic t_abort();
		int s0 = stops;
		mst.start();
		mst.xfer(4, {8'h00, 1'b1}, in);
		mst.stop();
		chk("stop", stops, s0 + 1);
		chk("stop stby", standby_o, 1);
		chk("idle", bus_idle_o, 1);
		mst.start();
		mst.xfer(9, {8'h5a, 1'b1}, in);
		chk("reframe ack", in[0], 0);
		chk("reframe rx", rx_byte_o, 8'h5a);
		mst.stop();
	endtask
	// Clock enable low freezes the block; an ACK-able byte passes unseen
	task automatic t_freeze();
		int s0 = starts;
		int v0 = valids;
		@(posedge clk_i);
		en_i <= 1'b0;
		#3;
		mst.start();
		mst.xfer(9, {8'h5a, 1'b1}, in);
		mst.stop();
		chk("frz ack", in[0], 1);
		chk("frz start", starts, s0);
		chk("frz rx", valids, v0);
		chk("frz stby", standby_o, 1);
		@(posedge clk_i);
		en_i <= 1'b1;
	endtask
	// Bus traffic during a mid-run reset is ignored
	task automatic t_rst_ignore();
		int s0 = starts;
		set_user(0, 8'h00, 1);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		#3;
		mst.start();
		mst.xfer(9, {8'h5a, 1'b1}, in);
		mst.stop();
		chk("rst ack", in[0], 1);
		chk("rst start", starts, s0);
		chk("rst stby", standby_o, 1);
		@(posedge clk_i);
		nrst_i <= 1'b1;
		// Outputs must still show their reset values two edges after release
		repeat (2) @(posedge clk_i);
		#1;
		chk("rel stby", standby_o, 1);
		chk("rel oe_n", sda_oe_n_o, 1);
		chk("rel rx", rx_byte_o, 0);
		chk("rel idle", bus_idle_o, 1);
	endtask
	initial begin
		{nrst_i, tx_mode_i, ack_en_i, tx_data_i} = '0;
		en_i = 1'b1;
		t_reset();
		t_glitch();
		t_write();
		t_read();
		t_abort();
		t_freeze();
		t_rst_ignore();
		complete_run();
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire
